// file: rtl/sfr_pkg.sv
// Shared constants and types for the serial flash read engine
package sfr_pkg;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_FAST = 3'h1, OP_DOUT = 3'h2,
    OP_DIO = 3'h3, OP_QOUT = 3'h4, OP_QIO = 3'h5
  } sfr_op_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_CMD = 6'h02, ST_ADDR = 6'h04,
    ST_DUMMY = 6'h08, ST_DATA = 6'h10, ST_IGNORE = 6'h20
  } sfr_state_t;

  // ==========================================================
  // Command codes, single edge
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST = 8'h0b;
  localparam logic [7:0] CMD_DOUT = 8'h3b;
  localparam logic [7:0] CMD_DIO = 8'hbb;
  localparam logic [7:0] CMD_QOUT = 8'h6b;
  localparam logic [7:0] CMD_QIO = 8'heb;
  // Dedicated four-byte codes, single edge
  localparam logic [7:0] CMD4_READ = 8'h13;
  localparam logic [7:0] CMD4_FAST = 8'h0c;
  localparam logic [7:0] CMD4_DOUT = 8'h3c;
  localparam logic [7:0] CMD4_DIO = 8'hbc;
  localparam logic [7:0] CMD4_QOUT = 8'h6c;
  localparam logic [7:0] CMD4_QIO = 8'hec;
  // Double-edge codes
  localparam logic [7:0] DCMD_FAST = 8'h0d;
  localparam logic [7:0] DCMD_DOUT = 8'h3d;
  localparam logic [7:0] DCMD_DIO = 8'hbd;
  localparam logic [7:0] DCMD_QOUT = 8'h6d;
  localparam logic [7:0] DCMD_QIO = 8'hed;

  // ==========================================================
  // Protocol select and lane widths
  localparam logic [1:0] PROTO_EXT = 2'h0;
  localparam logic [1:0] PROTO_DUAL = 2'h1;
  localparam logic [1:0] PROTO_QUAD = 2'h2;
  localparam logic [5:0] W1 = 6'h01;
  localparam logic [5:0] W2 = 6'h02;
  localparam logic [5:0] W4 = 6'h04;

  // ==========================================================
  // Phase lengths, address layout, lane enables
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int DIE_BITS = 25;
  localparam logic [24:0] DIE_STEP = 25'h0000001;
  localparam logic [3:0] OE_OFF = 4'hf;
  localparam logic [3:0] OE_LANE1 = 4'hd;
  localparam logic [3:0] OE_DUAL = 4'hc;
  localparam logic [3:0] OE_QUAD = 4'h0;

  // ==========================================================
  // Buffer shape and reset values
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] SYNC_HIGH = 2'h3;
  localparam logic [1:0] SYNC_LOW = 2'h0;

endpackage : sfr_pkg

// file: rtl/sfr_byte_fifo.sv
// Byte FIFO with registered read data between array and shifter
`timescale 1ns/100ps
module sfr_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic load;

  // ==========================================================
  // Handshake terms
  assign inReady = (count_q != FULL);
  assign push = inValid & inReady & ~flush;
  assign load = (count_q != '0) & (~outValid | outReady) & ~flush;

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else if (flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wrPtr_q <= AW'(wrPtr_q + 1'b1);
      if (load) rdPtr_q <= AW'(rdPtr_q + 1'b1);
      count_q <= (AW + 1)'(count_q + push - load);
    end
  end

  // Registered output stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (flush) begin
      outValid <= 1'b0;
    end else if (load) begin
      outValid <= 1'b1;
      outData <= mem_q[rdPtr_q];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

endmodule : sfr_byte_fifo

// file: rtl/sfr_read_engine.sv
// Serial flash read command decoder, address capture and lane sequencer
`timescale 1ns/100ps
module sfr_read_engine (
  input wire logic clk,
  input wire logic resetn,
  input wire logic chipSelN,
  input wire logic serialClk,
  input wire logic [3:0] activeLanesIn,
  output logic [3:0] activeLanesOut,
  output logic [3:0] activeLanesOeN,
  input wire logic [1:0] protocolSel,
  input wire logic doubleEdgeMode,
  input wire logic fourByteNv,
  input wire logic fourByteEnter,
  input wire logic fourByteExit,
  input wire logic [4:0] dummyCycles,
  output logic fourByteActive,
  output logic arrayRd,
  output logic [31:0] arrayAddr,
  input wire logic arrayRdValid,
  input wire logic [7:0] arrayRdData
);

  // ==========================================================
  // Functions
  function automatic logic [5:0] protoWidth(input logic [1:0] p);
    case (p)
      sfr_pkg::PROTO_DUAL: protoWidth = sfr_pkg::W2;
      sfr_pkg::PROTO_QUAD: protoWidth = sfr_pkg::W4;
      default: protoWidth = sfr_pkg::W1;
    endcase
  endfunction : protoWidth

  // Address lanes per variant and protocol
  function automatic logic [5:0] addrWidth(input sfr_pkg::sfr_op_t o,
                                           input logic [1:0] p);
    if (p != sfr_pkg::PROTO_EXT) addrWidth = protoWidth(p);
    else if (o == sfr_pkg::OP_DIO) addrWidth = sfr_pkg::W2;
    else if (o == sfr_pkg::OP_QIO) addrWidth = sfr_pkg::W4;
    else addrWidth = sfr_pkg::W1;
  endfunction : addrWidth

  // Data lanes per variant and protocol
  function automatic logic [5:0] dataWidth(input sfr_pkg::sfr_op_t o,
                                           input logic [1:0] p);
    if (p != sfr_pkg::PROTO_EXT) dataWidth = protoWidth(p);
    else if (o == sfr_pkg::OP_DOUT || o == sfr_pkg::OP_DIO)
      dataWidth = sfr_pkg::W2;
    else if (o == sfr_pkg::OP_QOUT || o == sfr_pkg::OP_QIO)
      dataWidth = sfr_pkg::W4;
    else dataWidth = sfr_pkg::W1;
  endfunction : dataWidth

  // Variant allowed under the protocol
  function automatic logic supported(input sfr_pkg::sfr_op_t o,
                                     input logic [1:0] p);
    case (p)
      sfr_pkg::PROTO_EXT: supported = 1'b1;
      sfr_pkg::PROTO_DUAL: supported = (o == sfr_pkg::OP_FAST) ||
        (o == sfr_pkg::OP_DOUT) || (o == sfr_pkg::OP_DIO);
      sfr_pkg::PROTO_QUAD: supported = (o == sfr_pkg::OP_FAST) ||
        (o == sfr_pkg::OP_QOUT) || (o == sfr_pkg::OP_QIO);
      default: supported = 1'b0;
    endcase
  endfunction : supported

  // Decode: {valid, force four bytes, variant}
  function automatic logic [4:0] decode(input logic [7:0] c,
                                        input logic dtr);
    decode = 5'h00;
    if (!dtr) begin
      case (c)
        sfr_pkg::CMD_READ: decode = {2'b10, sfr_pkg::OP_READ};
        sfr_pkg::CMD_FAST: decode = {2'b10, sfr_pkg::OP_FAST};
        sfr_pkg::CMD_DOUT: decode = {2'b10, sfr_pkg::OP_DOUT};
        sfr_pkg::CMD_DIO: decode = {2'b10, sfr_pkg::OP_DIO};
        sfr_pkg::CMD_QOUT: decode = {2'b10, sfr_pkg::OP_QOUT};
        sfr_pkg::CMD_QIO: decode = {2'b10, sfr_pkg::OP_QIO};
        sfr_pkg::CMD4_READ: decode = {2'b11, sfr_pkg::OP_READ};
        sfr_pkg::CMD4_FAST: decode = {2'b11, sfr_pkg::OP_FAST};
        sfr_pkg::CMD4_DOUT: decode = {2'b11, sfr_pkg::OP_DOUT};
        sfr_pkg::CMD4_DIO: decode = {2'b11, sfr_pkg::OP_DIO};
        sfr_pkg::CMD4_QOUT: decode = {2'b11, sfr_pkg::OP_QOUT};
        sfr_pkg::CMD4_QIO: decode = {2'b11, sfr_pkg::OP_QIO};
        default: decode = 5'h00;
      endcase
    end else begin
      case (c)
        sfr_pkg::DCMD_FAST: decode = {2'b10, sfr_pkg::OP_FAST};
        sfr_pkg::DCMD_DOUT: decode = {2'b10, sfr_pkg::OP_DOUT};
        sfr_pkg::DCMD_DIO: decode = {2'b10, sfr_pkg::OP_DIO};
        sfr_pkg::DCMD_QOUT: decode = {2'b10, sfr_pkg::OP_QOUT};
        sfr_pkg::DCMD_QIO: decode = {2'b10, sfr_pkg::OP_QIO};
        default: decode = 5'h00;
      endcase
    end
  endfunction : decode

  // Shift incoming lanes into the low end, lane 3 most significant
  function automatic logic [31:0] shiftIn(input logic [31:0] s,
                                          input logic [3:0] d,
                                          input logic [5:0] w);
    case (w)
      sfr_pkg::W1: shiftIn = {s[30:0], d[0]};
      sfr_pkg::W2: shiftIn = {s[29:0], d[1:0]};
      default: shiftIn = {s[27:0], d};
    endcase
  endfunction : shiftIn

  // Place the top bits of a byte on the output lanes
  function automatic logic [3:0] laneMap(input logic [7:0] b,
                                         input logic [5:0] w);
    case (w)
      sfr_pkg::W1: laneMap = {2'b00, b[7], 1'b0};
      sfr_pkg::W2: laneMap = {2'b00, b[7:6]};
      default: laneMap = b[7:4];
    endcase
  endfunction : laneMap

  // ==========================================================
  // Declarations
  sfr_pkg::sfr_state_t state_q;
  sfr_pkg::sfr_op_t op_q;
  logic [1:0] csSync_q;
  logic [1:0] sclkSync_q;
  logic [3:0] dqMeta_q;
  logic [3:0] dqSync_q;
  logic sclkPrev_q;
  logic csHigh;
  logic sclkRise;
  logic sclkFall;
  logic inEdge;
  logic shiftEv;
  logic [31:0] sh_q;
  logic [31:0] shNext;
  logic [5:0] bitCnt_q;
  logic [5:0] bitNext;
  logic [5:0] inW;
  logic [5:0] dataW;
  logic [5:0] addrLen_q;
  logic [4:0] dec;
  logic cmdDone;
  logic goodCmd;
  logic addrDone;
  logic [31:0] startAddr;
  logic [4:0] dummyCnt_q;
  logic initDone_q;
  logic fourByte_q;
  logic fetchOn_q;
  logic pending_q;
  logic drop_q;
  logic [31:0] fetchAddr_q;
  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [7:0] fifoOutData;
  logic [7:0] outSh_q;
  logic [3:0] outBits_q;

  // ==========================================================
  // Pin synchronisers and clock edge detect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      csSync_q <= sfr_pkg::SYNC_HIGH;
      sclkSync_q <= sfr_pkg::SYNC_LOW;
      dqMeta_q <= 4'h0;
      dqSync_q <= 4'h0;
      sclkPrev_q <= 1'b0;
    end else begin
      csSync_q <= {csSync_q[0], chipSelN};
      sclkSync_q <= {sclkSync_q[0], serialClk};
      dqMeta_q <= activeLanesIn;
      dqSync_q <= dqMeta_q;
      sclkPrev_q <= sclkSync_q[1];
    end
  end

  assign csHigh = csSync_q[1];
  assign sclkRise = sclkSync_q[1] & ~sclkPrev_q;
  assign sclkFall = ~sclkSync_q[1] & sclkPrev_q;
  assign inEdge = sclkRise | (doubleEdgeMode & sclkFall);
  assign shiftEv = doubleEdgeMode ? (sclkRise | sclkFall) : sclkFall;

  // ==========================================================
  // Phase decode
  always_comb begin
    inW = (state_q == sfr_pkg::ST_ADDR) ? addrWidth(op_q, protocolSel)
                                        : protoWidth(protocolSel);
    dataW = dataWidth(op_q, protocolSel);
    shNext = shiftIn(sh_q, dqSync_q, inW);
    bitNext = 6'(bitCnt_q + inW);
    dec = decode(shNext[7:0], doubleEdgeMode);
    cmdDone = (bitNext == sfr_pkg::CMD_BITS);
    goodCmd = dec[4] &
      supported(sfr_pkg::sfr_op_t'(dec[2:0]), protocolSel);
    addrDone = (state_q == sfr_pkg::ST_ADDR) & inEdge & ~csHigh &
               (bitNext == addrLen_q);
    startAddr = (addrLen_q == sfr_pkg::ADDR4_BITS) ? shNext
                : {8'h00, shNext[23:0]};
  end

  // Transaction state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= sfr_pkg::ST_IDLE;
    end else if (csHigh) begin
      state_q <= sfr_pkg::ST_IDLE;
    end else begin
      case (state_q)
        sfr_pkg::ST_IDLE: state_q <= sfr_pkg::ST_CMD;
        sfr_pkg::ST_CMD: begin
          if (sclkRise && cmdDone) begin
            state_q <= goodCmd ? sfr_pkg::ST_ADDR
                               : sfr_pkg::ST_IGNORE;
          end
        end
        sfr_pkg::ST_ADDR: begin
          if (addrDone) begin
            state_q <= (op_q != sfr_pkg::OP_READ && dummyCycles != 5'h00)
                      ? sfr_pkg::ST_DUMMY : sfr_pkg::ST_DATA;
          end
        end
        sfr_pkg::ST_DUMMY: begin
          if (sclkRise && dummyCnt_q == 5'h01) state_q <= sfr_pkg::ST_DATA;
        end
        sfr_pkg::ST_DATA: state_q <= sfr_pkg::ST_DATA;
        sfr_pkg::ST_IGNORE: state_q <= sfr_pkg::ST_IGNORE;
        default: state_q <= sfr_pkg::ST_IDLE;
      endcase
    end
  end

  // Command and address shifter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_q <= 32'h0;
      bitCnt_q <= 6'h00;
      op_q <= sfr_pkg::OP_READ;
      addrLen_q <= sfr_pkg::ADDR3_BITS;
    end else if (csHigh) begin
      bitCnt_q <= 6'h00;
    end else if (state_q == sfr_pkg::ST_CMD && sclkRise) begin
      sh_q <= shNext;
      bitCnt_q <= cmdDone ? 6'h00 : bitNext;
      if (cmdDone) begin
        op_q <= sfr_pkg::sfr_op_t'(dec[2:0]);
        addrLen_q <= (dec[3] | fourByte_q) ? sfr_pkg::ADDR4_BITS
                                           : sfr_pkg::ADDR3_BITS;
      end
    end else if (state_q == sfr_pkg::ST_ADDR && inEdge) begin
      sh_q <= shNext;
      bitCnt_q <= bitNext;
    end
  end

  // Dummy clock counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dummyCnt_q <= 5'h00;
    end else if (addrDone) begin
      dummyCnt_q <= dummyCycles;
    end else if (state_q == sfr_pkg::ST_DUMMY && sclkRise) begin
      dummyCnt_q <= 5'(dummyCnt_q - 5'h01);
    end
  end

  // Addressing mode, strap caught after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      initDone_q <= 1'b0;
      fourByte_q <= 1'b0;
    end else if (!initDone_q) begin
      initDone_q <= 1'b1;
      fourByte_q <= fourByteNv;
    end else if (fourByteEnter) begin
      fourByte_q <= 1'b1;
    end else if (fourByteExit) begin
      fourByte_q <= 1'b0;
    end
  end
  assign fourByteActive = fourByte_q;

  // ==========================================================
  // Array prefetch into the FIFO, one read outstanding
  assign arrayRd = fetchOn_q & ~pending_q & fifoInReady & ~csHigh;
  assign arrayAddr = fetchAddr_q;
  assign fifoInValid = arrayRdValid & pending_q & ~drop_q & fetchOn_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fetchOn_q <= 1'b0;
      fetchAddr_q <= 32'h0;
    end else if (csHigh) begin
      fetchOn_q <= 1'b0;
    end else if (addrDone) begin
      fetchOn_q <= 1'b1;
      fetchAddr_q <= startAddr;
    end else if (arrayRd) begin
      fetchAddr_q[sfr_pkg::DIE_BITS-1:0] <=
        sfr_pkg::DIE_BITS'(fetchAddr_q[sfr_pkg::DIE_BITS-1:0] +
                           sfr_pkg::DIE_STEP);
    end
  end

  // Outstanding read and stale answer tracking
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      if (arrayRd) pending_q <= 1'b1;
      else if (arrayRdValid) pending_q <= 1'b0;
      if (arrayRdValid) drop_q <= 1'b0;
      else if (csHigh && pending_q) drop_q <= 1'b1;
    end
  end

  sfr_byte_fifo #(
    .WIDTH(sfr_pkg::FIFO_WIDTH),
    .DEPTH(sfr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .flush(csHigh),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(arrayRdData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // ==========================================================
  // Output shifter and lane drive
  assign fifoOutReady = (state_q == sfr_pkg::ST_DATA) & ~csHigh & shiftEv &
                        (outBits_q == 4'h0);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outSh_q <= 8'h00;
      outBits_q <= 4'h0;
      activeLanesOut <= 4'h0;
      activeLanesOeN <= sfr_pkg::OE_OFF;
    end else if (csHigh || state_q != sfr_pkg::ST_DATA) begin
      outBits_q <= 4'h0;
      activeLanesOeN <= sfr_pkg::OE_OFF;
    end else if (shiftEv) begin
      if (outBits_q == 4'h0) begin
        if (fifoOutValid) begin
          activeLanesOut <= laneMap(fifoOutData, dataW);
          outSh_q <= 8'(fifoOutData << dataW);
          outBits_q <= 4'(sfr_pkg::BYTE_BITS - dataW[3:0]);
          activeLanesOeN <= ~laneMap(8'hff, dataW);
        end
      end else begin
        activeLanesOut <= laneMap(outSh_q, dataW);
        outSh_q <= 8'(outSh_q << dataW);
        outBits_q <= 4'(outBits_q - dataW[3:0]);
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cbMain @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_csRise;
    csHigh && !$past(csHigh);
  endsequence
  sequence s_cmdDone;
    state_q == sfr_pkg::ST_CMD && sclkRise && cmdDone && !csHigh;
  endsequence
  sequence s_dataOn;
    state_q == sfr_pkg::ST_DATA && activeLanesOeN != sfr_pkg::OE_OFF;
  endsequence

  property p_abort;
    s_csRise |=> state_q == sfr_pkg::ST_IDLE ##0
      activeLanesOeN == sfr_pkg::OE_OFF;
  endproperty
  a_abort: assert property (p_abort)
    else $error("lanes still driven after chip select rose");

  property p_cmdRiseOnly;
    (state_q == sfr_pkg::ST_CMD && !sclkRise && !csHigh) |=>
      $stable(bitCnt_q);
  endproperty
  a_cmdRiseOnly: assert property (p_cmdRiseOnly)
    else $error("command bit taken without rising edge");

  property p_fourByteCode;
    s_cmdDone ##0 (dec[3] && goodCmd) |=>
      addrLen_q == sfr_pkg::ADDR4_BITS ##0 state_q == sfr_pkg::ST_ADDR;
  endproperty
  a_fourByteCode: assert property (p_fourByteCode)
    else $error("dedicated code not given four address bytes");

  property p_threeByte;
    s_cmdDone ##0 !(dec[3] || fourByte_q) |=>
      addrLen_q == sfr_pkg::ADDR3_BITS;
  endproperty
  a_threeByte: assert property (p_threeByte)
    else $error("three-byte mode length wrong");

  property p_ignore;
    s_cmdDone ##0 !goodCmd |=> (state_q == sfr_pkg::ST_IGNORE &&
      activeLanesOeN == sfr_pkg::OE_OFF && !arrayRd)[*2];
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("unsupported code produced activity");

  property p_dummyQuiet;
    state_q == sfr_pkg::ST_DUMMY |-> activeLanesOeN == sfr_pkg::OE_OFF;
  endproperty
  a_dummyQuiet: assert property (p_dummyQuiet)
    else $error("lanes driven during dummy clocks");

  property p_extLanes;
    s_dataOn ##0 protocolSel == sfr_pkg::PROTO_EXT &&
      (op_q == sfr_pkg::OP_READ || op_q == sfr_pkg::OP_FAST) |->
      activeLanesOeN == sfr_pkg::OE_LANE1;
  endproperty
  a_extLanes: assert property (p_extLanes)
    else $error("single lane read not on lane one");

  property p_dualLanes;
    s_dataOn ##0 protocolSel == sfr_pkg::PROTO_DUAL |->
      activeLanesOeN == sfr_pkg::OE_DUAL;
  endproperty
  a_dualLanes: assert property (p_dualLanes)
    else $error("dual protocol data not on two lanes");

  property p_quadLanes;
    s_dataOn ##0 protocolSel == sfr_pkg::PROTO_QUAD |->
      activeLanesOeN == sfr_pkg::OE_QUAD;
  endproperty
  a_quadLanes: assert property (p_quadLanes)
    else $error("quad protocol data not on four lanes");

  property p_dieWrap;
    arrayRd && !addrDone |=> fetchAddr_q[31:sfr_pkg::DIE_BITS] ==
      $past(fetchAddr_q[31:sfr_pkg::DIE_BITS]);
  endproperty
  a_dieWrap: assert property (p_dieWrap)
    else $error("read address left its die");

  property p_dtrAddr;
    state_q == sfr_pkg::ST_ADDR && doubleEdgeMode && sclkFall &&
      !csHigh && !addrDone |=> bitCnt_q != $past(bitCnt_q);
  endproperty
  a_dtrAddr: assert property (p_dtrAddr)
    else $error("falling edge address bit missed");

  property p_strap;
    !initDone_q |=> fourByte_q == $past(fourByteNv);
  endproperty
  a_strap: assert property (p_strap)
    else $error("addressing mode strap not taken");

endmodule : sfr_read_engine

// file: testbench/sfr_host_model.sv
// Host serial controller model that frames read commands
`timescale 1ns/100ps
module sfr_host_model (
  input wire logic clk,
  input wire logic [3:0] laneWire,
  output logic chipSelN,
  output logic serialClk,
  output logic [3:0] hostVal,
  output logic [3:0] hostEn
);
  logic [7:0] got[$];
  // Idle: deselected, serial clock parked low, lanes released
  initial begin
    chipSelN = 1'b1;
    serialClk = 1'b0;
    hostVal = 4'h0;
    hostEn = 4'h0;
  end
  // One serial clock: lanes set while low, sampled just before the rise
  task automatic tick(input logic [3:0] v, input int w,
                      output logic [3:0] s);
    serialClk = 1'b0;
    hostVal = v;
    hostEn = 4'((1 << w) - 1);
    repeat (8) @(negedge clk);
    s = laneWire;
    serialClk = 1'b1;
    repeat (8) @(negedge clk);
  endtask : tick
  // Half clock for double edge: lanes set mid-half, then one edge
  task automatic half(input logic [3:0] v, input int w,
                      output logic [3:0] s);
    repeat (4) @(negedge clk);
    hostVal = v;
    hostEn = 4'((1 << w) - 1);
    repeat (4) @(negedge clk);
    s = laneWire;
    serialClk = ~serialClk;
  endtask : half
  // One transfer slot in the active edge mode
  task automatic step(input logic [3:0] v, input int w, dr,
                      output logic [3:0] s);
    if (dr) half(v, w, s);
    else tick(v, w, s);
  endtask : step
  // Full frame, then a partial byte and deselect in mid-data
  task automatic frame(input logic [7:0] c, input logic [31:0] a,
                       input int na, cw, aw, dw, dm, nb, dr);
    logic [3:0] s;
    logic [7:0] b;
    int i;
    got = {};
    chipSelN = 1'b0;
    repeat (4) @(negedge clk);
    for (i = 8; i > 0; i -= cw) tick(4'(c >> (i - cw)), cw, s);
    for (i = na; i > 0; i -= aw) begin
      step(4'(a >> (i - aw)), aw, dr, s);
    end
    repeat (dr ? 2 * dm : dm) step(4'h0, 0, dr, s);
    if (dr) half(4'h0, 0, s);
    repeat (nb) begin
      b = 8'h00;
      for (i = 0; i < 8; i += dw) begin
        step(4'h0, 0, dr, s);
        b = (dw == 1) ? {b[6:0], s[1]} :
            (dw == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
      end
      got.push_back(b);
    end
    tick(4'h0, 0, s);
    serialClk = 1'b0;
    chipSelN = 1'b1;
    repeat (8) @(negedge clk);
  endtask : frame
endmodule : sfr_host_model

// file: testbench/tb_sfr_read_engine.sv
// Self-checking bench for the serial flash read engine
`timescale 1ns/100ps
module tb_sfr_read_engine;
  logic clk = 0, resetn = 0, tgl = 0, sawDrive = 0;
  logic dtr = 0, fourByteNv = 0, rdSeen = 0;
  logic [31:0] rdAddr = 32'h0;
  logic fourByteEnter = 0, fourByteExit = 0, arrayRdValid = 0;
  logic [1:0] protocolSel = 2'h0;
  logic [4:0] dummyCycles = 5'h00;
  logic [7:0] arrayRdData = 8'h00;
  logic [3:0] laneOut, laneOeN, hostVal, hostEn, laneWire, seenOe;
  logic chipSelN, serialClk, fourByteActive, arrayRd;
  logic [31:0] arrayAddr;
  int failures = 0, checks_done = 0, cyc = 0, rdCount = 0, k, dm;
  logic [7:0] cd[6] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h6b, 8'heb};
  int aws[6] = '{1, 1, 1, 2, 1, 4};
  int dws[6] = '{1, 1, 2, 2, 4, 4};
  always #4 clk = ~clk;
  // Wire level: device where enabled, else host, else a moving pattern
  assign laneWire = (~laneOeN & laneOut) |
    (laneOeN & ((hostEn & hostVal) | (~hostEn & {4{tgl}})));
  sfr_read_engine sfr_read_engine_inst (.clk(clk), .resetn(resetn),
    .chipSelN(chipSelN), .serialClk(serialClk),
    .activeLanesIn(laneWire), .activeLanesOut(laneOut),
    .activeLanesOeN(laneOeN), .protocolSel(protocolSel),
    .doubleEdgeMode(dtr), .fourByteNv(fourByteNv),
    .fourByteEnter(fourByteEnter), .fourByteExit(fourByteExit),
    .dummyCycles(dummyCycles), .fourByteActive(fourByteActive),
    .arrayRd(arrayRd), .arrayAddr(arrayAddr),
    .arrayRdValid(arrayRdValid), .arrayRdData(arrayRdData));
  sfr_host_model sfr_host_model_inst (.clk(clk), .laneWire(laneWire),
    .chipSelN(chipSelN), .serialClk(serialClk), .hostVal(hostVal),
    .hostEn(hostEn));
  function automatic logic [7:0] memf(input logic [31:0] x);
    return x[7:0] ^ x[15:8] ^ x[23:16] ^ x[31:24] ^ 8'h5a;
  endfunction : memf
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[31:25], x[24:0] + 25'h0000001};
  endfunction : nxt
  // Read strobe and address as taken by the array
  always @(posedge clk) begin
    rdSeen <= arrayRd;
    rdAddr <= arrayAddr;
  end
  // Array answers one cycle later, lane watch, timeout
  always @(negedge clk) begin
    tgl = ~tgl;
    cyc++;
    arrayRdValid = rdSeen;
    arrayRdData = memf(rdAddr);
    if (arrayRd === 1'b1) rdCount++;
    if (laneOeN !== 4'hf) sawDrive = 1'b1;
    if (laneOeN !== 4'hf) seenOe = laneOeN;
    if (cyc == 60000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic run(input logic [7:0] c, input logic [31:0] x,
                     input int na, cw, aw, dw, dm, ok);
    int i;
    rdCount = 0;
    sawDrive = 1'b0;
    sfr_host_model_inst.frame(c, x, na, cw, aw, dw, dm, 3, dtr);
    check(laneOeN, 4'hf);
    check(sawDrive, ok);
    check(rdCount != 0, ok);
    if (ok) check(seenOe, dw == 1 ? 4'hd : dw == 2 ? 4'hc : 4'h0);
    for (i = 0; i < 3 && ok; i++) begin
      check(sfr_host_model_inst.got[i], memf(x));
      x = nxt(x);
    end
  endtask : run
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    void'($urandom(20799));
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    check(fourByteActive, 0);
    for (k = 0; k < 6; k++) begin
      dm = (k == 0) ? 0 : $urandom % 8;
      dummyCycles = 5'(dm);
      run(cd[k], {8'h00, 24'($urandom)}, 24, 1, aws[k], dws[k], dm, 1);
    end
    protocolSel = 2'h2;
    run(8'h0b, {8'h00, 24'($urandom)}, 24, 4, 4, 4, dm, 1);
    protocolSel = 2'h1;
    run(8'h6b, {8'h00, 24'($urandom)}, 24, 2, 2, 2, dm, 0);
    run(8'h3b, {8'h00, 24'($urandom)}, 24, 2, 2, 2, dm, 1);
    protocolSel = 2'h0;
    run(8'h13, 32'h03ffffff, 32, 1, 1, 1, 0, 1);
    fourByteEnter = 1'b1;
    @(negedge clk);
    fourByteEnter = 1'b0;
    @(negedge clk);
    check(fourByteActive, 1);
    run(8'h0b, 32'($urandom), 32, 1, 1, 1, dm, 1);
    fourByteExit = 1'b1;
    @(negedge clk);
    fourByteExit = 1'b0;
    @(negedge clk);
    check(fourByteActive, 0);
    // Double-edge reads, plain read has no code there
    dtr = 1'b1;
    run(8'hbd, {8'h00, 24'($urandom)}, 24, 1, 2, 2, dm, 1);
    run(8'h03, {8'h00, 24'($urandom)}, 24, 1, 1, 1, 0, 0);
    // Second reset with the four-byte strap set
    fourByteNv = 1'b1;
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    check(fourByteActive, 1);
    print_verdict();
  end
endmodule : tb_sfr_read_engine
